// ==== hw/buck_fault_pkg.sv ====
// Shared constants for the two-channel buck fault supervisor.
package buck_fault_pkg;
	// Number of regulator channels
	localparam int unsigned CHANNELS = 2;
	// Clock period of the internal oscillator domain
	localparam int unsigned CLK_PERIOD_PS = 5000;
	// Deglitch and fault timer intervals, in their printed units
	localparam int unsigned OC_TIME_NS = 53000;
	localparam int unsigned UV_TIME_NS = 27000;
	localparam int unsigned OV_TIME_PS = 1500000;
	// Nominal switching frequency of each channel
	localparam int unsigned SW_FREQ_KHZ = 300;
	// Counter width, wide enough for the longest timer
	localparam int unsigned CNT_W = 14;
	// Cycle counts derived from the times (all three divide exactly)
	localparam logic [CNT_W-1:0] OC_CYCLES = CNT_W'(OC_TIME_NS * 1000 / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] UV_CYCLES = CNT_W'(UV_TIME_NS * 1000 / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] OV_CYCLES = CNT_W'(OV_TIME_PS / CLK_PERIOD_PS);
	// One switching period in oscillator cycles, and its half for interleave
	localparam logic [CNT_W-1:0] SW_PERIOD_CYCLES = CNT_W'(64'd1000000000 / (SW_FREQ_KHZ * CLK_PERIOD_PS));
	localparam logic [CNT_W-1:0] SW_HALF_CYCLES = CNT_W'(SW_PERIOD_CYCLES / 2);
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
	localparam logic [1:0] DRIVE_RESET = 2'h0;
endpackage

// ==== hw/buck_fault_protection_logic.sv ====
// Fault supervision and gate-drive gating for both buck channels.
`timescale 1ns/10ps
`default_nettype none
module buck_fault_protection_logic
	import buck_fault_pkg::*;
#(
	// Long timers, shortened in simulation if wanted
	parameter logic [buck_fault_pkg::CNT_W-1:0] OC_FAULT_CYCLES = buck_fault_pkg::OC_CYCLES,
	parameter logic [buck_fault_pkg::CNT_W-1:0] UV_FAULT_CYCLES = buck_fault_pkg::UV_CYCLES
)
(
	input wire logic i_clk,
	input wire logic i_nrst,
	// Power-stage input supply above its start level
	input wire logic i_vin_ok,
	// Controller supply above its start level
	input wire logic i_vcc_ok,
	// Die over-temperature comparator, with its own release hysteresis
	input wire logic i_over_temp,
	// Per-channel enable
	input wire logic [1:0] i_en,
	// Per-channel comparator outputs
	input wire logic [1:0] i_overcurrent,
	input wire logic [1:0] i_overvoltage,
	input wire logic [1:0] i_undervoltage,
	// Drive requests from the PWM control blocks
	input wire logic [1:0] i_pwm_hs,
	input wire logic [1:0] i_pwm_ls,
	// Gated drive enables to the gate drivers
	output logic [1:0] o_hs_drive,
	output logic [1:0] o_ls_drive,
	// Interleaved switching clocks to the PWM blocks
	output logic [1:0] o_sw_clk,
	// Fault and status indications
	output logic [1:0] o_overcurrent_guard,
	output logic [1:0] o_overvoltage_guard,
	output logic [1:0] o_output_low_guard,
	output logic o_thermal_fault,
	output logic o_supply_lockout
);
	// Whole module state
	typedef struct packed
	{
		logic [1:0] hs;
		logic [1:0] ls;
		logic [1:0] oc_lat;
		logic [1:0] ov_lat;
		logic [1:0] uv_lat;
		logic [1:0] cut;
		logic [1:0] en_d;
		logic ot_lat;
		logic vcc_d;
		logic lockout;
	} prot_state_s;

	prot_state_s st_reg;
	prot_state_s st_next;

	// Both supplies up and no thermal fault
	logic run_ok;
	// Channel enabled and allowed to run
	logic [1:0] active;
	// Controller supply came back this cycle
	logic vcc_rise;
	// Any enable re-applied this cycle
	logic en_rise;
	// Per-channel latch clear request
	logic [1:0] clr;
	// Counter activity and expiry per channel
	logic [1:0] oc_act;
	logic [1:0] ov_act;
	logic [1:0] uv_act;
	logic [1:0] oc_exp;
	logic [1:0] ov_exp;
	logic [1:0] uv_exp;
	logic [CNT_W-1:0] oc_count [1:0];
	logic [CNT_W-1:0] ov_count [1:0];
	logic [CNT_W-1:0] uv_count [1:0];
	// Start-of-cycle pulses from the divider
	logic [1:0] cycle_start;

	// Order of arrival of the two supplies does not matter, only both levels
	assign run_ok = i_vin_ok && i_vcc_ok && !st_reg.ot_lat;
	assign active = {2{run_ok}} & i_en;
	// A counter whose own fault is latched stops timing; undervoltage timing is
	// suppressed while an overvoltage latch stands
	assign oc_act = active & i_overcurrent & ~st_reg.oc_lat;
	assign ov_act = active & i_overvoltage & ~st_reg.ov_lat;
	assign uv_act = active & i_undervoltage & ~st_reg.ov_lat & ~st_reg.uv_lat;

	// Switching clocks come from the same oscillator as all fault timing
	switch_clock_divider u_divider
	(
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.o_sw_clk(o_sw_clk),
		.o_cycle_start(cycle_start)
	);

	// Three persistence counters per channel, with per-channel assertions
	generate
		for (genvar c = 0; c < CHANNELS; c++)
		begin : g_chan
			fault_deglitch #(.LIMIT(OC_FAULT_CYCLES)) u_oc
			(
				.i_clk(i_clk),
				.i_nrst(i_nrst),
				.i_active(oc_act[c]),
				.o_count(oc_count[c]),
				.o_expired(oc_exp[c])
			);
			fault_deglitch #(.LIMIT(OV_CYCLES)) u_ov
			(
				.i_clk(i_clk),
				.i_nrst(i_nrst),
				.i_active(ov_act[c]),
				.o_count(ov_count[c]),
				.o_expired(ov_exp[c])
			);
			fault_deglitch #(.LIMIT(UV_FAULT_CYCLES)) u_uv
			(
				.i_clk(i_clk),
				.i_nrst(i_nrst),
				.i_active(uv_act[c]),
				.o_count(uv_count[c]),
				.o_expired(uv_exp[c])
			);

			// Overcurrent blanks the high side in the next cycle
			property p_oc_cut;
				@(posedge i_clk) disable iff (!i_nrst)
				i_overcurrent[c] |=> !o_hs_drive[c];
			endproperty
			a_oc_cut: assert property (p_oc_cut) else $error("high side on after overcurrent");

			// Overcurrent latch only after the full timer ran
			property p_oc_latch;
				@(posedge i_clk) disable iff (!i_nrst)
				$rose(st_reg.oc_lat[c]) |-> ($past(oc_count[c]) == OC_FAULT_CYCLES - 14'h0001);
			endproperty
			a_oc_latch: assert property (p_oc_latch) else $error("overcurrent latched early");

			// Overvoltage latch only after the full deglitch interval
			property p_ov_latch;
				@(posedge i_clk) disable iff (!i_nrst)
				$rose(st_reg.ov_lat[c]) |-> ($past(ov_count[c]) == OV_CYCLES - 14'h0001 && $past(i_overvoltage[c]));
			endproperty
			a_ov_latch: assert property (p_ov_latch) else $error("overvoltage latched early");

			// Latched overvoltage: high side off, low side tracks comparator
			property p_ov_drive;
				@(posedge i_clk) disable iff (!i_nrst)
				(st_reg.ov_lat[c] && run_ok && i_en[c]) |=> (!o_hs_drive[c] && o_ls_drive[c] == $past(i_overvoltage[c]));
			endproperty
			a_ov_drive: assert property (p_ov_drive) else $error("overvoltage drive pattern wrong");

			// No undervoltage latch appears while overvoltage is latched
			property p_uv_mask;
				@(posedge i_clk) disable iff (!i_nrst)
				(st_reg.ov_lat[c] && !st_reg.uv_lat[c]) |=> !st_reg.uv_lat[c];
			endproperty
			a_uv_mask: assert property (p_uv_mask) else $error("undervoltage set under overvoltage");

			// Latched undervoltage without overvoltage turns both drives off
			property p_uv_off;
				@(posedge i_clk) disable iff (!i_nrst)
				(st_reg.uv_lat[c] && !st_reg.ov_lat[c]) |=> (!o_hs_drive[c] && !o_ls_drive[c]);
			endproperty
			a_uv_off: assert property (p_uv_off) else $error("drive on with undervoltage latched");

			// Undervoltage latch only after the full fault timer ran unmasked
			property p_uv_latch;
				@(posedge i_clk) disable iff (!i_nrst)
				$rose(st_reg.uv_lat[c]) |-> ($past(uv_count[c]) == UV_FAULT_CYCLES - 14'h0001 && $past(uv_act[c]));
			endproperty
			a_uv_latch: assert property (p_uv_latch) else $error("undervoltage latched early");

			// A latch holds while supply stays and enable is steady
			property p_latch_hold;
				@(posedge i_clk) disable iff (!i_nrst)
				(st_reg.oc_lat[c] && i_vcc_ok && i_en[c] == st_reg.en_d[c]) |=> st_reg.oc_lat[c];
			endproperty
			a_latch_hold: assert property (p_latch_hold) else $error("overcurrent latch lost");

			// Deglitch counter restarts when its indication drops
			property p_ov_restart;
				@(posedge i_clk) disable iff (!i_nrst)
				!ov_act[c] |=> (ov_count[c] == CNT_RESET);
			endproperty
			a_ov_restart: assert property (p_ov_restart) else $error("deglitch counter kept counting");
		end
	endgenerate

	// Latch, clear and drive-gating decisions for the whole block
	always_comb
	begin
		st_next = st_reg;
		vcc_rise = i_vcc_ok && !st_reg.vcc_d;
		en_rise = |(i_en & ~st_reg.en_d);
		st_next.vcc_d = i_vcc_ok;
		st_next.en_d = i_en;
		st_next.lockout = !(i_vin_ok && i_vcc_ok);
		// Thermal release needs both a re-apply event and a cooled die;
		// a re-apply while still hot is simply ignored
		st_next.ot_lat = i_over_temp || (st_reg.ot_lat && !((vcc_rise || en_rise) && !i_over_temp));
		clr = 2'h0;
		for (int c = 0; c < CHANNELS; c++)
		begin
			// Controller supply loss or either edge of the channel's own enable clears; a new event wins
			clr[c] = !i_vcc_ok || (i_en[c] != st_reg.en_d[c]);
			st_next.oc_lat[c] = (st_reg.oc_lat[c] && !clr[c]) || oc_exp[c];
			st_next.ov_lat[c] = (st_reg.ov_lat[c] && !clr[c]) || ov_exp[c];
			st_next.uv_lat[c] = (st_reg.uv_lat[c] && !clr[c]) || uv_exp[c];
			// Pulse stays cut until the channel's next switching cycle
			st_next.cut[c] = (st_reg.cut[c] && !cycle_start[c]) || i_overcurrent[c];
			if (!run_ok || !i_en[c])
			begin
				// Lockout and thermal shutdown dominate everything
				st_next.hs[c] = 1'b0;
				st_next.ls[c] = 1'b0;
			end
			else if (st_reg.ov_lat[c])
			begin
				// Discharge the output through the low side on demand
				st_next.hs[c] = 1'b0;
				st_next.ls[c] = i_overvoltage[c];
			end
			else if (st_reg.oc_lat[c] || st_reg.uv_lat[c])
			begin
				// Latched off, both switches open
				st_next.hs[c] = 1'b0;
				st_next.ls[c] = 1'b0;
			end
			else
			begin
				// Normal operation with cycle-by-cycle current limit
				st_next.hs[c] = i_pwm_hs[c] && !i_overcurrent[c] && !st_reg.cut[c];
				st_next.ls[c] = i_pwm_ls[c];
			end
		end
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			st_reg <= '{hs: DRIVE_RESET, ls: DRIVE_RESET, oc_lat: 2'h0, ov_lat: 2'h0, uv_lat: 2'h0,
				cut: 2'h0, en_d: 2'h0, ot_lat: 1'b0, vcc_d: 1'b0, lockout: 1'b1};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign o_hs_drive = st_reg.hs;
	assign o_ls_drive = st_reg.ls;
	assign o_overcurrent_guard = st_reg.oc_lat;
	assign o_overvoltage_guard = st_reg.ov_lat;
	assign o_output_low_guard = st_reg.uv_lat;
	assign o_thermal_fault = st_reg.ot_lat;
	assign o_supply_lockout = st_reg.lockout;

	// Lockout or thermal fault turns all drives off next cycle
	property p_lockout_off;
		@(posedge i_clk) disable iff (!i_nrst)
		(!i_vin_ok || !i_vcc_ok || st_reg.ot_lat) |=> (o_hs_drive == 2'h0 && o_ls_drive == 2'h0);
	endproperty
	a_lockout_off: assert property (p_lockout_off) else $error("drive on during lockout");

	// Lockout flag follows both supplies
	property p_supply_start;
		@(posedge i_clk) disable iff (!i_nrst)
		(i_vin_ok && i_vcc_ok) |=> !o_supply_lockout;
	endproperty
	a_supply_start: assert property (p_supply_start) else $error("lockout with both supplies up");

	// Thermal fault sets at once and holds while hot
	property p_thermal;
		@(posedge i_clk) disable iff (!i_nrst)
		i_over_temp |=> o_thermal_fault [*1] ##0 (i_over_temp || o_thermal_fault);
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal fault not held");

	// Thermal release only after a re-apply event with cool die
	property p_thermal_release;
		@(posedge i_clk) disable iff (!i_nrst)
		$fell(st_reg.ot_lat) |-> ($past(!i_over_temp) && ($past(vcc_rise) || $past(en_rise)));
	endproperty
	a_thermal_release: assert property (p_thermal_release) else $error("thermal fault released early");

	// At a channel 0 start pulse, channel 1 is not starting and only clock 0 is high
	property p_interleave;
		@(posedge i_clk) disable iff (!i_nrst)
		cycle_start[0] |-> (!cycle_start[1] && o_sw_clk == 2'h1);
	endproperty
	a_interleave: assert property (p_interleave) else $error("switching clocks not interleaved");
endmodule
`default_nettype wire

// ==== hw/fault_deglitch.sv ====
// Persistence counter that expires after a run of active cycles.
`timescale 1ns/10ps
`default_nettype none
module fault_deglitch
	import buck_fault_pkg::*;
#(
	parameter logic [buck_fault_pkg::CNT_W-1:0] LIMIT = 14'h0001
)
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_active,
	output logic [buck_fault_pkg::CNT_W-1:0] o_count,
	output logic o_expired
);
	// Whole module state
	typedef struct packed
	{
		logic [CNT_W-1:0] count;
	} deglitch_state_s;

	deglitch_state_s st_reg;
	deglitch_state_s st_next;

	// Expiry is combinational so the latch sets on the last active cycle
	assign o_expired = i_active && (st_reg.count == LIMIT - 14'h0001);
	assign o_count = st_reg.count;

	// Count while active, hold at the end, restart on any drop
	always_comb
	begin
		st_next = st_reg;
		if (!i_active)
		begin
			st_next.count = CNT_RESET;
		end
		else if (st_reg.count != LIMIT - 14'h0001)
		begin
			st_next.count = st_reg.count + 14'h0001;
		end
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			st_reg <= '{count: CNT_RESET};
		else
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

// ==== hw/switch_clock_divider.sv ====
// Divider producing two interleaved switching clocks from the oscillator.
`timescale 1ns/10ps
`default_nettype none
module switch_clock_divider
	import buck_fault_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	output logic [1:0] o_sw_clk,
	output logic [1:0] o_cycle_start
);
	// Whole module state
	typedef struct packed
	{
		logic [CNT_W-1:0] count;
		logic [1:0] sw_clk;
		logic [1:0] start;
	} divider_state_s;

	divider_state_s st_reg;
	divider_state_s st_next;

	assign o_sw_clk = st_reg.sw_clk;
	assign o_cycle_start = st_reg.start;

	// Channel 1 starts half a period after channel 0 for 180 degree interleave
	always_comb
	begin
		st_next = st_reg;
		if (st_reg.count == SW_PERIOD_CYCLES - 14'h0001)
			st_next.count = CNT_RESET;
		else
			st_next.count = st_reg.count + 14'h0001;
		st_next.start[0] = (st_next.count == CNT_RESET);
		st_next.start[1] = (st_next.count == SW_HALF_CYCLES);
		st_next.sw_clk[0] = (st_next.count < SW_HALF_CYCLES);
		st_next.sw_clk[1] = !(st_next.count < SW_HALF_CYCLES);
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			st_reg <= '{count: CNT_RESET, sw_clk: 2'h0, start: 2'h0};
		else
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

// ==== tb/buck_stage_model.sv ====
// Behavioural power stage: PWM requests, analog comparators and gate driver watch.
`timescale 1ns/10ps
`default_nettype none
module buck_stage_model
(
	input wire logic i_clk,
	input wire logic [1:0] i_duty,
	input wire logic [1:0] i_oc_event,
	input wire logic [1:0] i_ov_event,
	input wire logic [1:0] i_uv_event,
	input wire logic [1:0] i_hs_drive,
	input wire logic [1:0] i_ls_drive,
	output logic [1:0] o_pwm_hs,
	output logic [1:0] o_pwm_ls,
	output logic [1:0] o_overcurrent,
	output logic [1:0] o_overvoltage,
	output logic [1:0] o_undervoltage,
	output logic o_shoot_through
);
	// Controller requests are complementary, so a request never asks for shoot-through
	assign o_pwm_hs = i_duty;
	assign o_pwm_ls = ~i_duty;
	// Comparators are level outputs, always driven by the analog side
	assign o_overcurrent = i_oc_event;
	assign o_overvoltage = i_ov_event;
	assign o_undervoltage = i_uv_event;
	// Sticky flag: both switches of one leg on would short the input rail;
	// unknown drives before the first reset edge do not count as an overlap
	logic seen_overlap = 1'b0;
	assign o_shoot_through = seen_overlap;
	always @(posedge i_clk)
	begin
		if ((|(i_hs_drive & i_ls_drive)) === 1'b1)
		begin
			seen_overlap <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the buck fault supervisor.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import buck_fault_pkg::*;
	// Short timers keep the run brief; expectations derive from these
	localparam int OCN = 20;
	localparam int UVN = 10;
	logic i_clk, i_nrst, i_vin_ok, i_vcc_ok, i_over_temp;
	logic [1:0] i_en, duty, f_oc, f_ov, f_uv, pwm_hs, pwm_ls, oc, ov, uv;
	logic [1:0] hs, ls, sw_clk, g_oc, g_ov, g_uv;
	logic therm, lockout, shoot;
	int failures, n_checks, cycles;
	// Free-running 200 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	buck_fault_protection_logic #(.OC_FAULT_CYCLES(14'h0014), .UV_FAULT_CYCLES(14'h000a)) dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_vin_ok(i_vin_ok), .i_vcc_ok(i_vcc_ok),
		.i_over_temp(i_over_temp), .i_en(i_en), .i_overcurrent(oc), .i_overvoltage(ov),
		.i_undervoltage(uv), .i_pwm_hs(pwm_hs), .i_pwm_ls(pwm_ls), .o_hs_drive(hs),
		.o_ls_drive(ls), .o_sw_clk(sw_clk), .o_overcurrent_guard(g_oc), .o_overvoltage_guard(g_ov),
		.o_output_low_guard(g_uv), .o_thermal_fault(therm), .o_supply_lockout(lockout));
	buck_stage_model stage (.i_clk(i_clk), .i_duty(duty), .i_oc_event(f_oc), .i_ov_event(f_ov),
		.i_uv_event(f_uv), .i_hs_drive(hs), .i_ls_drive(ls), .o_pwm_hs(pwm_hs), .o_pwm_ls(pwm_ls),
		.o_overcurrent(oc), .o_overvoltage(ov), .o_undervoltage(uv), .o_shoot_through(shoot));
	// Inputs change at the falling edge, away from the sampling edge
	task automatic tick(input int n = 1);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		n_checks++;
		if (got != exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Either supply low raises lockout, input supply low blocks both channels; release checked with the input supply up first, controller supply last
	task automatic t_lockout;
		i_vin_ok = 1'b0;
		tick(2);
		chk({1'b0, lockout}, 2'h1);
		chk(hs, 2'h0);
		i_vin_ok = 1'b1;
		i_vcc_ok = 1'b0;
		tick(2);
		chk({1'b0, lockout}, 2'h1);
		i_vcc_ok = 1'b1;
		tick(2);
		chk({1'b0, lockout}, 2'h0);
		chk(hs, 2'h3);
	endtask
	// Channel 0 overcurrent: pulse cut, restart on a gap, latch, clear by enable toggle
	task automatic t_oc;
		f_oc = 2'h1;
		tick();
		chk(hs, 2'h2);
		tick(OCN - 4);
		f_oc = 2'h0;
		tick();
		f_oc = 2'h1;
		tick(OCN - 2);
		chk(g_oc, 2'h0);
		tick(3);
		chk(g_oc, 2'h1);
		duty = 2'h0;
		tick(2);
		chk(ls, 2'h2);
		duty = 2'h3;
		f_oc = 2'h0;
		tick(3);
		chk(g_oc, 2'h1);
		i_en = 2'h2;
		tick(2);
		i_en = 2'h3;
		tick(2);
		chk(g_oc, 2'h0);
	endtask
	// Channel 1 overvoltage: short event ignored, full event latches, low side follows
	task automatic t_ov;
		f_ov = 2'h2;
		tick(299);
		f_ov = 2'h0;
		tick(2);
		chk(g_ov, 2'h0);
		chk(hs & 2'h2, 2'h2);
		f_ov = 2'h2;
		tick(302);
		chk(g_ov, 2'h2);
		chk(hs & 2'h2, 2'h0);
		chk(ls & 2'h2, 2'h2);
		duty = 2'h1;
		f_ov = 2'h0;
		tick(2);
		chk(ls & 2'h2, 2'h0);
		f_uv = 2'h2;
		tick(UVN + 4);
		chk(g_uv, 2'h0);
		f_oc = 2'h2;
		tick(OCN + 4);
		chk(g_oc, 2'h2);
		f_ov = 2'h2;
		tick(2);
		chk(ls & 2'h2, 2'h2);
		chk(hs & 2'h2, 2'h0);
		f_ov = 2'h0;
		f_uv = 2'h0;
		f_oc = 2'h0;
		duty = 2'h3;
		i_vcc_ok = 1'b0;
		tick(2);
		i_vcc_ok = 1'b1;
		tick(2);
		chk(g_ov, 2'h0);
		chk(g_oc, 2'h0);
	endtask
	// Channel 0 undervoltage persists to expiry, both switches off
	task automatic t_uv;
		duty = 2'h0;
		f_uv = 2'h1;
		tick(UVN - 2);
		chk(g_uv, 2'h0);
		tick(3);
		chk(g_uv, 2'h1);
		tick();
		chk(ls, 2'h2);
		f_uv = 2'h0;
		i_en = 2'h2;
		tick(2);
		i_en = 2'h3;
		duty = 2'h3;
		tick(2);
		chk(g_uv, 2'h0);
	endtask
	// Thermal shutdown: re-enable while hot is ignored, cooling alone does not release, re-enable when cool releases
	task automatic t_therm;
		i_over_temp = 1'b1;
		tick(2);
		chk({1'b0, therm}, 2'h1);
		chk(hs, 2'h0);
		i_en = 2'h0;
		tick();
		i_en = 2'h3;
		tick(2);
		chk({1'b0, therm}, 2'h1);
		i_over_temp = 1'b0;
		tick(2);
		chk({1'b0, therm}, 2'h1);
		i_en = 2'h0;
		tick();
		i_en = 2'h3;
		tick(2);
		chk({1'b0, therm}, 2'h0);
	endtask
	// Interleaved switching clocks: half period of channel 0 high, channel 1 opposite
	task automatic t_clk;
		int n;
		n = 0;
		while (sw_clk[0] !== 1'b0 && n < 700)
		begin
			tick();
			n++;
		end
		while (sw_clk[0] !== 1'b1 && n < 1400)
		begin
			tick();
			n++;
		end
		n = 0;
		while (sw_clk[0] === 1'b1 && n < 700)
		begin
			if (n == 5)
				chk(sw_clk, 2'h1);
			tick();
			n++;
		end
		chk_n(n, int'(SW_HALF_CYCLES));
	endtask
	// Hang guard
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			close_out();
		end
	end
	initial
	begin
		failures = 0;
		n_checks = 0;
		cycles = 0;
		i_nrst = 1'b0;
		i_vin_ok = 1'b1;
		i_vcc_ok = 1'b1;
		i_over_temp = 1'b0;
		i_en = 2'h3;
		duty = 2'h3;
		f_oc = 2'h0;
		f_ov = 2'h0;
		f_uv = 2'h0;
		tick(6);
		chk({1'b0, lockout}, 2'h1);
		i_nrst = 1'b1;
		tick(2);
		t_lockout();
		t_oc();
		t_ov();
		t_uv();
		t_therm();
		t_clk();
		chk({1'b0, shoot}, 2'h0);
		close_out();
	end
endmodule
`default_nettype wire
